/* plsd_pkg.sv */
package plsd_pkg;

	// ----------------------------------------------------------------
	// Register indices on the plain register port
	// ----------------------------------------------------------------
	localparam logic [3:0] LINK_CONTROL_REG_IDX      = 4'h0;
	localparam logic [3:0] LINK_STATUS_REG_IDX       = 4'h1;
	localparam logic [3:0] LINK_CONTROL_TWO_REG_IDX  = 4'h2;
	localparam logic [3:0] PHY_LINK_CONFIG_REG_IDX   = 4'h3;
	localparam logic [3:0] PHY_LINK_STATE_REG_IDX    = 4'h4;
	localparam logic [3:0] UNCORR_ERR_STATUS_REG_IDX = 4'h5;
	localparam logic [3:0] DEVICE_CAPS_REG_IDX       = 4'h6;
	localparam logic [3:0] SLOT_CAPS_REG_IDX         = 4'h7;
	localparam logic [3:0] PORT_STATUS_REG_IDX       = 4'h8;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int LINK_RETRAIN_BIT       = 5;
	localparam int BW_MGMT_STATUS_BIT     = 14;
	localparam int AUTONOMOUS_BW_BIT      = 15;
	localparam int SPEED_LO_BIT           = 0;
	localparam int HW_AUTO_SPEED_DIS_BIT  = 5;
	localparam int INIT_SPEED_INHIBIT_BIT = 0;
	localparam int FULL_RETRAIN_BIT       = 0;
	localparam int SURPRISE_DOWN_BIT      = 5;
	localparam int POWER_SCALE_LO         = 18;
	localparam int POWER_VALUE_LO         = 26;
	localparam int SLOT_POWER_VALUE_LO    = 7;
	localparam int PHASE_FIELD_LO         = 0;
	localparam int LINK_UP_BIT            = 4;

	// ----------------------------------------------------------------
	// Encodings and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0] SPEED_GEN1        = 4'h1;
	localparam logic [3:0] SPEED_GEN2        = 4'h2;
	localparam logic [3:0] TARGET_SPEED_RST  = SPEED_GEN2;
	localparam logic [0:0] HW_AUTO_SPEED_DIS = 1'h0;
	localparam logic [1:0] RATES_BOTH        = 2'h3;
	localparam logic [1:0] RATES_GEN1        = 2'h1;
	localparam logic [31:0] SLOT_CAPS_RST    = 32'h0000_0000;

	// Link trainer phases as seen by this controller.
	typedef enum logic [2:0] {
		PH_DETECT,
		PH_TRAIN,
		PH_ACTIVE,
		PH_SPEEDUP,
		PH_RETRAIN
	} plsd_phase_t;

	// Link layer events reported by the physical and data-link layers.
	typedef struct packed {
		logic dlUp;
		logic changeDone;
		logic changeOk;
		logic phyUnreliable;
		logic partnerUpReq;
		logic partnerGen2;
		logic partnerAuto;
	} plsd_link_in_t;

	// Commands from this block to the link trainer.
	typedef struct packed {
		logic       goDetect;
		logic       startChange;
		logic [3:0] changeSpeed;
		logic [1:0] advRates;
		logic       autoChangeFlag;
	} plsd_link_out_t;

	// Slot power limit message, both directions.
	typedef struct packed {
		logic       valid;
		logic [7:0] byte0;
		logic [7:0] byte1;
	} plsd_power_msg_t;

	// Traffic handling when the link goes down, and credit advertisement when it comes up.
	typedef struct packed {
		logic flushIngress;
		logic flushReplay;
		logic hotReset;
		logic rejectUr;
		logic dropOther;
		logic advertiseCredits;
	} plsd_traffic_t;

endpackage : plsd_pkg

/* plsd_port_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module plsd_port_ctrl
	import plsd_pkg::*;
(
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            resetn,
	// Port configuration
	input  wire logic            isDownstream,
	input  wire logic            partitionDisabled,
	input  wire logic            portDisabled,
	input  wire logic            modeChangeRetrain,
	input  wire logic            clockModeChange,
	input  wire logic            surpriseDownEvent,
	// Register port
	input  wire logic [3:0]      regAddr,
	input  wire logic [31:0]     regWdata,
	input  wire logic            regWrite,
	input  wire logic            regRead,
	output logic      [31:0]     regRdata,
	// Link layer
	input  wire plsd_link_in_t   linkIn,
	output plsd_link_out_t       linkOut,
	// Slot power limit messages
	input  wire plsd_power_msg_t powerRx,
	output plsd_power_msg_t      powerTx,
	// Traffic steering
	output plsd_traffic_t        traffic,
	// Packets to the port's own functions are always served
	output logic                 ownFuncServe
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		plsd_phase_t     phase;
		logic [3:0]      targetSpeed;
		logic [3:0]      curSpeed;
		logic            inhibit;
		logic            retrainReq;
		logic            initTried;
		logic            bwMgmt;
		logic            autoBw;
		logic            surpriseDown;
		logic            advGen2;
		logic            dlUpPrev;
		logic            isUpgrade;
		logic            fullRetrain;
		logic [7:0]      powerScale;
		logic [1:0]      powerValue;
		logic [31:0]     slotCaps;
		logic [31:0]     rdata;
		plsd_link_out_t  lo;
		plsd_power_msg_t ptx;
		plsd_traffic_t   tr;
	} plsd_state_t;

	plsd_state_t st_r;
	plsd_state_t st_nxt;

	logic wrCtl;
	logic wrCtl2;
	logic wrCfg;
	logic wrState;
	logic wrStatus;
	logic wrErr;
	logic wrSlot;

	assign wrCtl    = regWrite && regAddr == LINK_CONTROL_REG_IDX;
	assign wrCtl2   = regWrite && regAddr == LINK_CONTROL_TWO_REG_IDX;
	assign wrCfg    = regWrite && regAddr == PHY_LINK_CONFIG_REG_IDX;
	assign wrState  = regWrite && regAddr == PHY_LINK_STATE_REG_IDX;
	assign wrStatus = regWrite && regAddr == LINK_STATUS_REG_IDX;
	assign wrErr    = regWrite && regAddr == UNCORR_ERR_STATUS_REG_IDX;
	assign wrSlot   = regWrite && regAddr == SLOT_CAPS_REG_IDX;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic linkDown;
		logic sdSuppress;
		logic retrainKick;
		logic fullKick;
		linkDown    = 1'b0;
		sdSuppress  = 1'b0;
		retrainKick = 1'b0;
		fullKick    = 1'b0;
		st_nxt = st_r;
		st_nxt.lo.startChange = 1'b0;
		st_nxt.lo.goDetect    = 1'b0;
		st_nxt.ptx.valid      = 1'b0;
		st_nxt.dlUpPrev       = linkIn.dlUp;

		if (wrCtl2) begin
			st_nxt.targetSpeed = regWdata[SPEED_LO_BIT +: 4];
		end
		if (wrCfg) begin
			st_nxt.inhibit = regWdata[INIT_SPEED_INHIBIT_BIT];
		end
		if (wrSlot) begin
			st_nxt.slotCaps = regWdata;
		end
		retrainKick = wrCtl && regWdata[LINK_RETRAIN_BIT];
		fullKick    = wrState && regWdata[FULL_RETRAIN_BIT];
		if (retrainKick) begin
			st_nxt.retrainReq = 1'b1;
			// Advertisement follows the target on an explicit retrain.
			st_nxt.advGen2 = st_nxt.targetSpeed == SPEED_GEN2;
		end

		// Write-one-to-clear status bits; a new event wins over the clear.
		if (wrStatus && regWdata[BW_MGMT_STATUS_BIT]) begin
			st_nxt.bwMgmt = 1'b0;
		end
		if (wrStatus && regWdata[AUTONOMOUS_BW_BIT]) begin
			st_nxt.autoBw = 1'b0;
		end
		if (wrErr && regWdata[SURPRISE_DOWN_BIT]) begin
			st_nxt.surpriseDown = 1'b0;
		end

		case (st_r.phase)
			PH_DETECT: begin
				st_nxt.curSpeed  = SPEED_GEN1;
				st_nxt.phase     = PH_TRAIN;
				st_nxt.initTried = 1'b0;
			end
			PH_TRAIN: begin
				if (linkIn.dlUp) begin
					st_nxt.phase       = PH_ACTIVE;
					st_nxt.fullRetrain = 1'b0;
				end
			end
			PH_ACTIVE: begin
				// The automatic upgrade is offered only in the first cycle after link-up.
				st_nxt.initTried = 1'b1;
				if (!linkIn.dlUp) begin
					// Training after a drop starts again at the low rate.
					st_nxt.phase     = PH_TRAIN;
					st_nxt.curSpeed  = SPEED_GEN1;
					st_nxt.initTried = 1'b0;
					linkDown         = 1'b1;
				end else if (linkIn.partnerUpReq && st_r.curSpeed == SPEED_GEN1) begin
					// Partner request is always taken on.
					st_nxt.lo.startChange = 1'b1;
					st_nxt.lo.changeSpeed = SPEED_GEN2;
					st_nxt.isUpgrade      = 1'b1;
					st_nxt.phase          = PH_SPEEDUP;
				end else if (st_r.retrainReq) begin
					st_nxt.retrainReq     = 1'b0;
					st_nxt.lo.startChange = 1'b1;
					st_nxt.lo.changeSpeed = st_r.targetSpeed;
					st_nxt.isUpgrade      = st_r.targetSpeed == SPEED_GEN2;
					st_nxt.phase          = PH_RETRAIN;
				end else if (linkIn.phyUnreliable && st_r.curSpeed == SPEED_GEN2) begin
					st_nxt.lo.startChange = 1'b1;
					st_nxt.lo.changeSpeed = SPEED_GEN1;
					st_nxt.isUpgrade      = 1'b0;
					st_nxt.phase          = PH_RETRAIN;
				end else if (isDownstream && !st_r.inhibit && !st_r.initTried
						&& st_r.targetSpeed == SPEED_GEN2
						&& st_r.curSpeed == SPEED_GEN1) begin
					st_nxt.lo.startChange = 1'b1;
					st_nxt.lo.changeSpeed = SPEED_GEN2;
					st_nxt.isUpgrade      = 1'b1;
					st_nxt.phase          = PH_SPEEDUP;
				end
				if (linkIn.partnerAuto && isDownstream) begin
					st_nxt.autoBw = 1'b1;
				end
			end
			PH_SPEEDUP: begin
				// Initial or partner upgrade: bandwidth status is left alone.
				if (linkIn.changeDone) begin
					st_nxt.phase    = PH_ACTIVE;
					st_nxt.curSpeed = (linkIn.changeOk && linkIn.partnerGen2
						&& st_r.advGen2) ? SPEED_GEN2 : SPEED_GEN1;
				end
			end
			PH_RETRAIN: begin
				if (linkIn.changeDone) begin
					st_nxt.phase = PH_ACTIVE;
					if (linkIn.changeOk && st_r.isUpgrade && linkIn.partnerGen2
							&& st_r.advGen2) begin
						st_nxt.curSpeed = SPEED_GEN2;
					end else begin
						st_nxt.curSpeed = SPEED_GEN1;
						if (st_r.curSpeed == SPEED_GEN2) begin
							st_nxt.bwMgmt = 1'b1;
						end
					end
				end
			end
			default: begin
				st_nxt.phase = PH_DETECT;
			end
		endcase

		// Full retrain overrides the phase and any pending retrain request (not a startChange from the same cycle) and leaves bwMgmt alone.
		if (fullKick) begin
			st_nxt.phase       = PH_DETECT;
			st_nxt.lo.goDetect = 1'b1;
			st_nxt.fullRetrain = 1'b1;
			st_nxt.retrainReq  = 1'b0;
			st_nxt.bwMgmt      = st_r.bwMgmt;
			if (!(wrStatus && regWdata[BW_MGMT_STATUS_BIT])) begin
				st_nxt.bwMgmt = st_r.bwMgmt;
			end else begin
				st_nxt.bwMgmt = 1'b0;
			end
		end

		st_nxt.lo.advRates       = st_nxt.advGen2 ? RATES_BOTH : RATES_GEN1;
		st_nxt.lo.autoChangeFlag = 1'b0;

		// Surprise down report, masked by the listed causes.
		sdSuppress = partitionDisabled || portDisabled || modeChangeRetrain
			|| clockModeChange || st_r.fullRetrain || fullKick;
		if (surpriseDownEvent && isDownstream && !sdSuppress) begin
			st_nxt.surpriseDown = 1'b1;
		end

		// Traffic handling follows data-link state.
		st_nxt.tr.flushIngress     = !linkIn.dlUp;
		st_nxt.tr.flushReplay      = !linkIn.dlUp;
		st_nxt.tr.rejectUr         = isDownstream && !linkIn.dlUp;
		st_nxt.tr.dropOther        = isDownstream && !linkIn.dlUp;
		st_nxt.tr.hotReset         = !isDownstream && linkDown;
		st_nxt.tr.advertiseCredits = linkIn.dlUp && !st_r.dlUpPrev;

		// Slot power limit capture and send.
		if (!isDownstream && powerRx.valid) begin
			st_nxt.powerScale = powerRx.byte0;
			st_nxt.powerValue = powerRx.byte1[1:0];
		end
		if (isDownstream && ((wrSlot && linkIn.dlUp) || (linkIn.dlUp && !st_r.dlUpPrev))) begin
			st_nxt.ptx.valid = 1'b1;
			st_nxt.ptx.byte0 = wrSlot ? regWdata[SLOT_POWER_VALUE_LO +: 8]
				: st_r.slotCaps[SLOT_POWER_VALUE_LO +: 8];
			st_nxt.ptx.byte1 = 8'h00;
		end

		// Read data, valid in the cycle after the strobe.
		st_nxt.rdata = 32'h0000_0000;
		if (regRead) begin
			case (regAddr)
				LINK_STATUS_REG_IDX: begin
					st_nxt.rdata[SPEED_LO_BIT +: 4]  = st_r.curSpeed;
					st_nxt.rdata[BW_MGMT_STATUS_BIT] = st_r.bwMgmt;
					st_nxt.rdata[AUTONOMOUS_BW_BIT]  = st_r.autoBw;
				end
				LINK_CONTROL_TWO_REG_IDX: begin
					st_nxt.rdata[SPEED_LO_BIT +: 4]     = st_r.targetSpeed;
					st_nxt.rdata[HW_AUTO_SPEED_DIS_BIT] = HW_AUTO_SPEED_DIS;
				end
				PHY_LINK_CONFIG_REG_IDX: begin
					st_nxt.rdata[INIT_SPEED_INHIBIT_BIT] = st_r.inhibit;
				end
				UNCORR_ERR_STATUS_REG_IDX: begin
					st_nxt.rdata[SURPRISE_DOWN_BIT] = st_r.surpriseDown;
				end
				DEVICE_CAPS_REG_IDX: begin
					st_nxt.rdata[POWER_SCALE_LO +: 8] = st_r.powerScale;
					st_nxt.rdata[POWER_VALUE_LO +: 2] = st_r.powerValue;
				end
				SLOT_CAPS_REG_IDX: begin
					st_nxt.rdata = st_r.slotCaps;
				end
				PORT_STATUS_REG_IDX: begin
					st_nxt.rdata[PHASE_FIELD_LO +: $bits(plsd_phase_t)] = st_r.phase;
					st_nxt.rdata[LINK_UP_BIT]                           = linkIn.dlUp;
				end
				default: begin
					st_nxt.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (!resetn) begin
			st_r             <= '0;
			st_r.phase       <= PH_DETECT;
			st_r.targetSpeed <= TARGET_SPEED_RST;
			st_r.curSpeed    <= SPEED_GEN1;
			st_r.advGen2     <= 1'b1;
			st_r.slotCaps    <= SLOT_CAPS_RST;
			st_r.lo.advRates <= RATES_BOTH;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign regRdata     = st_r.rdata;
	assign linkOut      = st_r.lo;
	assign powerTx      = st_r.ptx;
	assign traffic      = st_r.tr;
	assign ownFuncServe = 1'b1;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	no_auto_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
		!linkOut.autoChangeFlag) else $error("autonomous change flag set");
	up_no_init_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!isDownstream && !linkIn.partnerUpReq && !st_r.retrainReq
		&& st_r.phase == PH_ACTIVE) |=> st_r.phase != PH_SPEEDUP)
		else $error("upstream started initial upgrade");
	inhibit_blocks_a: assert property (@(posedge mclk) disable iff (!resetn)
		(st_r.inhibit && !linkIn.partnerUpReq && st_r.phase == PH_ACTIVE)
		|=> st_r.phase != PH_SPEEDUP) else $error("inhibit ignored");
	speedup_no_bw_a: assert property (@(posedge mclk) disable iff (!resetn)
		(st_r.phase == PH_SPEEDUP && !st_r.bwMgmt) |=> !st_r.bwMgmt)
		else $error("upgrade set bw status");
	full_detect_a: assert property (@(posedge mclk) disable iff (!resetn)
		(wrState && regWdata[FULL_RETRAIN_BIT] && !wrStatus)
		|=> st_r.phase == PH_DETECT && $stable(st_r.bwMgmt))
		else $error("full retrain misbehaved");
	hw_autonomous_speed_disable_zero_a: assert property (@(posedge mclk) disable iff (!resetn)
		$past(regRead && regAddr == LINK_CONTROL_TWO_REG_IDX)
		|-> !regRdata[HW_AUTO_SPEED_DIS_BIT]) else $error("hw_autonomous_speed_disable not zero");
	downgrade_bw_a: assert property (@(posedge mclk) disable iff (!resetn)
		(st_r.phase == PH_RETRAIN && linkIn.changeDone && st_r.curSpeed == SPEED_GEN2
		&& st_nxt.curSpeed == SPEED_GEN1 && !(wrState && regWdata[FULL_RETRAIN_BIT]))
		|=> st_r.bwMgmt) else $error("bw not set");
	power_cap_a: assert property (@(posedge mclk) disable iff (!resetn)
		(!isDownstream && powerRx.valid) |=> st_r.powerScale == $past(powerRx.byte0)
		&& st_r.powerValue == $past(powerRx.byte1[1:0])) else $error("power capture");
	sd_suppress_a: assert property (@(posedge mclk) disable iff (!resetn)
		(portDisabled && !st_r.surpriseDown) |=> !st_r.surpriseDown)
		else $error("surprise down set while disabled");
	power_tx_a: assert property (@(posedge mclk) disable iff (!resetn)
		(isDownstream && linkIn.dlUp && !st_r.dlUpPrev) |=> powerTx.valid)
		else $error("no power message on link up");

	auto_up_c: cover property (@(posedge mclk) disable iff (!resetn)
		st_r.phase == PH_SPEEDUP ##[1:20] st_r.curSpeed == SPEED_GEN2);
	downgrade_c: cover property (@(posedge mclk) disable iff (!resetn)
		st_r.phase == PH_RETRAIN ##[1:20] st_r.bwMgmt);
	full_retrain_c: cover property (@(posedge mclk) disable iff (!resetn)
		st_r.lo.goDetect);
	link_down_c: cover property (@(posedge mclk) disable iff (!resetn)
		traffic.rejectUr);

endmodule : plsd_port_ctrl

`default_nettype wire

/* plsd_link_partner.sv */
`timescale 1ns/1ps
`default_nettype none

module plsd_link_partner
	import plsd_pkg::*;
(
	// Clock and reset
	input  wire logic           mclk,
	input  wire logic           resetn,
	// Bench controls
	input  wire logic           upCtl,
	input  wire logic           gen2Ctl,
	input  wire logic           failCtl,
	input  wire logic           slowCtl,
	input  wire logic           upReqCtl,
	input  wire logic           autoCtl,
	input  wire logic           badPhyCtl,
	// Link
	input  wire plsd_link_out_t linkOut,
	output plsd_link_in_t       linkIn
);
	int         waitCnt;
	logic [3:0] reqSpeed;
	logic       downHold;

	// A detect request takes the link down until the bench lets it come up again.
	always @(posedge mclk) begin
		if (!resetn) begin
			linkIn   <= '0;
			waitCnt  <= 0;
			downHold <= 1'h0;
		end else begin
			downHold            <= (downHold | linkOut.goDetect) & upCtl;
			linkIn.dlUp         <= upCtl & ~downHold & ~linkOut.goDetect;
			linkIn.partnerGen2  <= gen2Ctl;
			linkIn.partnerUpReq <= upReqCtl;
			linkIn.partnerAuto  <= autoCtl;
			linkIn.phyUnreliable <= badPhyCtl;
			linkIn.changeDone   <= 1'h0;
			linkIn.changeOk     <= 1'h0;
			if (linkOut.startChange) begin
				reqSpeed <= linkOut.changeSpeed;
				waitCnt  <= slowCtl ? 6 : 2;
			end else if (waitCnt == 1) begin
				linkIn.changeDone <= 1'h1;
				linkIn.changeOk   <= ~failCtl & ((reqSpeed == SPEED_GEN1) |
					(gen2Ctl & (linkOut.advRates == RATES_BOTH)));
				waitCnt <= 0;
			end else if (waitCnt > 1) begin
				waitCnt <= waitCnt - 1;
			end
		end
	end
endmodule : plsd_link_partner

`default_nettype wire

/* tb_pcie_port_speed_and_link_down_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_pcie_port_speed_and_link_down_ctrl import plsd_pkg::*;;
	logic            mclk     = 1'h0;
	logic            resetn   = 1'h0;
	logic            isDn     = 1'h1;
	logic [3:0]      supp     = 4'h0;
	logic [2:0]      pls      = 3'h0;
	logic [3:0]      regAddr  = 4'h0;
	logic [31:0]     regWdata = 32'h0;
	logic            regWrite = 1'h0;
	logic            regRead  = 1'h0;
	logic [31:0]     regRdata;
	plsd_link_in_t   linkIn;
	plsd_link_out_t  linkOut;
	plsd_power_msg_t powerRx  = '0;
	plsd_power_msg_t powerTx;
	plsd_traffic_t   traffic;
	logic            ownFuncServe;
	logic            upCtl = 1'h0, failCtl = 1'h0, slowCtl = 1'h0, badPhy = 1'h0, gen2 = 1'h1;
	int              badCount = 0, nChecks = 0, seed = 32'h05B00CF8;
	int              nStart, nDet, nPow, nHot, nCred, autoBad, expSpeed, s0, i;
	logic [3:0]      lastSpd;
	logic [7:0]      lastB0;
	logic [31:0]     rdv, d;

	always #20 mclk = ~mclk;

	plsd_port_ctrl u_dut (.mclk(mclk), .resetn(resetn), .isDownstream(isDn),
		.partitionDisabled(supp[0]), .portDisabled(supp[1]), .modeChangeRetrain(supp[2]),
		.clockModeChange(supp[3]), .surpriseDownEvent(pls[0]), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
		.linkIn(linkIn), .linkOut(linkOut), .powerRx(powerRx), .powerTx(powerTx),
		.traffic(traffic), .ownFuncServe(ownFuncServe));

	plsd_link_partner u_partner (.mclk(mclk), .resetn(resetn), .upCtl(upCtl),
		.gen2Ctl(gen2), .failCtl(failCtl), .slowCtl(slowCtl), .upReqCtl(pls[1]),
		.autoCtl(pls[2]), .badPhyCtl(badPhy), .linkOut(linkOut), .linkIn(linkIn));

	// ----------------------------------------------------------------
	// Pulse monitor
	// ----------------------------------------------------------------
	always @(posedge mclk) begin
		if (!resetn) begin
			{nStart, nDet, nPow, nHot, nCred, autoBad} <= '0;
		end else begin
			if (linkOut.startChange === 1'h1) begin
				nStart  <= nStart + 1;
				lastSpd <= linkOut.changeSpeed;
			end
			if (powerTx.valid === 1'h1) begin
				nPow   <= nPow + 1;
				lastB0 <= powerTx.byte0;
			end
			nDet    <= nDet + (linkOut.goDetect === 1'h1);
			nHot    <= nHot + (traffic.hotReset === 1'h1);
			nCred   <= nCred + (traffic.advertiseCredits === 1'h1);
			autoBad <= autoBad + (linkOut.autoChangeFlag !== 1'h0);
		end
	end

	// ----------------------------------------------------------------
	// Bus and check tasks
	// ----------------------------------------------------------------
	task automatic idle(input int n);
		repeat (n) @(posedge mclk);
	endtask : idle

	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge mclk);
		regAddr  <= a;
		regWdata <= v;
		regWrite <= 1'h1;
		@(posedge mclk);
		regWrite <= 1'h0;
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge mclk);
		regAddr <= a;
		regRead <= 1'h1;
		@(posedge mclk);
		regRead <= 1'h0;
		@(negedge mclk);
		rdv = regRdata;
		@(posedge mclk);
	endtask : rd

	task automatic pulse(input int k);
		@(posedge mclk);
		pls[k] <= 1'h1;
		@(posedge mclk);
		pls[k] <= 1'h0;
	endtask : pulse

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		nChecks++;
		if (seen !== exp) begin
			badCount++;
			$display("wrong value at %0t: %s saw %h expected %h", $time, what, seen, exp);
		end
	endtask : chk

	task automatic speedIs(input int s);
		expSpeed = s;
		rd(LINK_STATUS_REG_IDX);
		chk(rdv[3:0], expSpeed, "current speed");
	endtask : speedIs

	task automatic resetPort(input logic dn);
		@(posedge mclk);
		resetn <= 1'h0;
		isDn   <= dn;
		upCtl  <= 1'h0;
		idle(16);
		resetn <= 1'h1;
		@(posedge mclk);
	endtask : resetPort

	task automatic done(input string n);
		$display("test %s finished", n);
	endtask : done

	task automatic wrapUp;
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrapUp

	// A hang here would otherwise stall the whole regression.
	initial begin
		idle(20000);
		badCount++;
		wrapUp();
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		resetPort(1'h1);
		rd(LINK_CONTROL_TWO_REG_IDX);
		chk(rdv[3:0], TARGET_SPEED_RST, "target after reset");
		chk(linkOut.advRates, RATES_BOTH, "rates after reset");
		wr(LINK_CONTROL_TWO_REG_IDX, 32'h22);
		rd(LINK_CONTROL_TWO_REG_IDX);
		chk(rdv[HW_AUTO_SPEED_DIS_BIT], HW_AUTO_SPEED_DIS, "speed disable");
		rd(4'hF);
		chk(rdv, 32'h0, "unmapped read");
		speedIs(1);
		done("reset");
		upCtl <= 1'h1;
		idle(12);
		chk(nStart, 1, "auto upgrade");
		chk(lastSpd, SPEED_GEN2, "upgrade speed");
		chk(nCred, 1, "credits at link up");
		chk(nPow, 1, "power message at link up");
		speedIs(2);
		chk(rdv[BW_MGMT_STATUS_BIT], 1'h0, "bw after auto upgrade");
		pulse(2);
		idle(4);
		rd(LINK_STATUS_REG_IDX);
		chk(rdv[AUTONOMOUS_BW_BIT], 1'h1, "autonomous bw");
		d = $random(seed);
		wr(SLOT_CAPS_REG_IDX, d);
		idle(4);
		chk(nPow, 2, "power message on caps write");
		chk(lastB0, d[14:7], "power message scale");
		done("upgrade");
		slowCtl <= 1'h1;
		wr(LINK_CONTROL_TWO_REG_IDX, 32'h1);
		wr(LINK_CONTROL_REG_IDX, 32'h20);
		idle(14);
		chk(lastSpd, SPEED_GEN1, "downgrade speed");
		chk(linkOut.advRates, RATES_GEN1, "rates after downgrade");
		speedIs(1);
		chk(rdv[BW_MGMT_STATUS_BIT], 1'h1, "bw after downgrade");
		wr(PHY_LINK_STATE_REG_IDX, 32'h1);
		idle(4);
		chk(nDet, 1, "full retrain detect");
		rd(LINK_STATUS_REG_IDX);
		chk(rdv[BW_MGMT_STATUS_BIT], 1'h1, "bw after full retrain");
		upCtl <= 1'h0;
		idle(3);
		chk({traffic.flushIngress, traffic.flushReplay, traffic.rejectUr, traffic.dropOther},
			4'hF, "link down traffic");
		chk(ownFuncServe, 1'h1, "own functions");
		// The full retrain still masks surprise down until the link is back.
		pulse(0);
		idle(2);
		rd(UNCORR_ERR_STATUS_REG_IDX);
		chk(rdv[SURPRISE_DOWN_BIT], 1'h0, "surprise down after full retrain");
		done("downgrade");
		s0 = nStart;
		upCtl <= 1'h1;
		idle(12);
		chk(nStart, s0, "stays low");
		chk(nCred, 2, "credits again");
		for (i = 0; i < 5; i++) begin
			supp <= (i < 4) ? 4'h1 << i : 4'h0;
			pulse(0);
			idle(2);
			rd(UNCORR_ERR_STATUS_REG_IDX);
			chk(rdv[SURPRISE_DOWN_BIT], i == 4, "surprise down");
			wr(UNCORR_ERR_STATUS_REG_IDX, 32'h20);
		end
		pulse(1);
		idle(12);
		speedIs(1);
		wr(LINK_CONTROL_TWO_REG_IDX, 32'h2);
		wr(LINK_CONTROL_REG_IDX, 32'h20);
		idle(14);
		speedIs(2);
		badPhy <= 1'h1;
		idle(12);
		badPhy <= 1'h0;
		speedIs(1);
		chk(linkOut.advRates, RATES_BOTH, "rates after unreliable");
		failCtl <= 1'h1;
		pulse(1);
		idle(14);
		speedIs(1);
		s0 = nStart;
		idle(20);
		chk(nStart, s0, "no own retry");
		failCtl <= 1'h0;
		wr(LINK_CONTROL_REG_IDX, 32'h20);
		idle(14);
		speedIs(2);
		done("partner");
		resetPort(1'h0);
		upCtl <= 1'h1;
		idle(12);
		chk(nStart, 0, "upstream no upgrade");
		gen2 <= 1'h0;
		pulse(1);
		idle(12);
		speedIs(1);
		gen2 <= 1'h1;
		pulse(1);
		idle(12);
		speedIs(2);
		d = $random(seed);
		powerRx <= {1'h1, d[7:0], d[15:8]};
		@(posedge mclk);
		powerRx.valid <= 1'h0;
		idle(2);
		rd(DEVICE_CAPS_REG_IDX);
		chk(rdv[25:18], d[7:0], "captured scale");
		chk(rdv[27:26], d[9:8], "captured value");
		upCtl <= 1'h0;
		idle(4);
		chk(nHot, 1, "hot reset");
		chk({traffic.flushIngress, traffic.flushReplay}, 2'h3, "upstream flush");
		resetPort(1'h1);
		wr(PHY_LINK_CONFIG_REG_IDX, 32'h1);
		upCtl <= 1'h1;
		idle(12);
		chk(nStart, 0, "inhibited upgrade");
		chk(autoBad, 0, "autonomous flag");
		done("upstream");
		wrapUp();
	end
endmodule : tb_pcie_port_speed_and_link_down_ctrl

`default_nettype wire
